// [ecp_host_ctrl.sv]
// host controller that drives an ecp parallel port through its i/o registers
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// - from 000/001 any mode; otherwise only back to 000/001. (the code refuses 101 even from 000/001)
// - direction changes only in mode 001.
// - drain fifo before leaving forward extended mode; controls deassert.
// - after negotiation clear direction, strobe, auto-feed, then mode 011.
// - command port bytes go as commands, data port as data; forward only.
// - reverse channel via mode 001, negotiate, set direction, mode 011.
// - forward command msb one means channel address, else run count.
// - reverse command msb always zero; reverse channels optional.
// - compressed data: count to command port then data; avoid zero.
// - terminate ecp only while the channel runs forward.
module ecp_host_ctrl (
   input wire logic clk,
   input wire logic sys_rst,
   input wire ecp_host_pkg::host_req_t hostReq,
   output logic [7:0] rdData,
   input wire logic [7:0] devDataIn,
   output ecp_host_pkg::dev_bus_t devBus
);
   import ecp_host_pkg::*;

   // ****************************************
   // step table
   // ****************************************
   function automatic busop_t stepOf(op_t op, logic [1:0] idx, logic [7:0] a0,
                                     logic [7:0] a1);
      busop_t s;
      logic [7:0] dcrVal;
      s = '{K_END, OFF_ECR, 8'h00};
      dcrVal = DCR_BASE;
      dcrVal[DCR_DIR_BIT] = a0[0];
      case (op)
         OP_SETMODE: begin
            if (idx == 2'h0) s = '{K_POLL_E, OFF_ECR, 8'h00};
            else if (idx == 2'h1) s = '{K_WR, OFF_ECR, {a0[2:0], ECR_LOW}};
         end
         OP_SETDIR: if (idx == 2'h0) s = '{K_WR, OFF_DCR, dcrVal};
         OP_WRDATA: if (idx == 2'h0) s = '{K_WR, OFF_DATA_FIFO, a0};
         OP_WRCMD: if (idx == 2'h0) s = '{K_WR, OFF_CMD_FIFO, a0};
         OP_RDDATA: begin
            if (idx == 2'h0) s = '{K_POLL_NE, OFF_ECR, 8'h00};
            else if (idx == 2'h1) s = '{K_RD, OFF_DATA_FIFO, 8'h00};
         end
         OP_ECPSETUP: begin
            // direction, strobe and auto-feed all cleared before the mode
            if (idx == 2'h0) s = '{K_WR, OFF_DCR, DCR_BASE};
            else if (idx == 2'h1) s = '{K_WR, OFF_ECR, {M_ECP, ECR_LOW}};
         end
         OP_RLE: begin
            if (idx == 2'h0) s = '{K_WR, OFF_CMD_FIFO, {1'b0, a0[6:0]}};
            else if (idx == 2'h1) s = '{K_WR, OFF_DATA_FIFO, a1};
         end
         OP_RDCFG: if (idx == 2'h0) s = '{K_RD, a0[0] ? OFF_CFG_B : OFF_DATA_FIFO, 8'h00};
         default: s = '{K_END, OFF_ECR, 8'h00};
      endcase
      return s;
   endfunction

   // ****************************************
   // state
   // ****************************************
   state_t state_r;
   op_t op_r;
   mode_t curMode_r;
   logic curDir_r;
   logic errFlag_r;
   logic sawPoll_r;
   logic [1:0] idx_r;
   logic [3:0] cnt_r;
   logic [7:0] arg0_r;
   logic [7:0] arg1_r;
   logic [7:0] result_r;
   logic [7:0] syncA_r;
   logic [7:0] syncB_r;
   dev_bus_t devBus_r;

   // ****************************************
   // decode
   // ****************************************
   wire op_t newOp = op_t'(hostReq.wdata[2:0]);
   wire mode_t target = mode_t'(arg0_r[2:0]);
   wire logic launch = hostReq.wr && (hostReq.addr == REG_CMD);
   wire logic basicMode = (curMode_r == M_SPP) || (curMode_r == M_PS2);
   wire logic basicTarget = (target == M_SPP) || (target == M_PS2);
   wire logic fwdEcp = (curMode_r == M_ECP) && !curDir_r;
   wire logic revEcp = (curMode_r == M_ECP) && curDir_r;
   wire logic leaveFwd = ((curMode_r == M_FIFO) || fwdEcp) && basicTarget;
   wire logic modeOk = (basicMode || basicTarget) && (target != M_RSVD)
                       && !(revEcp && (target == M_SPP));
   logic cmdOk;
   always_comb begin
      case (newOp)
         OP_SETMODE: cmdOk = modeOk;
         OP_SETDIR: cmdOk = (curMode_r == M_PS2);
         OP_WRDATA: cmdOk = (curMode_r == M_FIFO) || fwdEcp || (curMode_r == M_TEST);
         OP_WRCMD: cmdOk = fwdEcp;
         OP_RDDATA: cmdOk = revEcp || (curMode_r == M_TEST);
         OP_ECPSETUP: cmdOk = (curMode_r == M_SPP);
         OP_RLE: cmdOk = fwdEcp && (arg0_r[6:0] != 7'h00);
         OP_RDCFG: cmdOk = (curMode_r == M_CFG);
         default: cmdOk = 1'b0;
      endcase
   end
   wire logic busy = (state_r != S_IDLE);
   wire logic accept = launch && !busy && cmdOk;
   wire logic [1:0] startIdx = ((newOp == OP_SETMODE) && !leaveFwd) ? 2'h1 : 2'h0;
   wire busop_t cur = stepOf(op_r, idx_r, arg0_r, arg1_r);
   wire busop_t first = stepOf(newOp, startIdx, arg0_r, arg1_r);
   wire logic isRead = (cur.kind != K_WR);
   wire logic emptyBit = syncB_r[ECR_EMPTY_BIT];
   wire logic pollMiss = ((cur.kind == K_POLL_E) && !emptyBit)
                         || ((cur.kind == K_POLL_NE) && emptyBit);
   wire logic strbEnd = (state_r == S_STRB) && (cnt_r == 4'h1);
   wire logic recEnd = (state_r == S_RECOV) && (cnt_r == 4'h1);
   wire logic [7:0] status = {busy, errFlag_r, 1'b0, curDir_r, 1'b0, curMode_r};
   logic [7:0] regMux;
   always_comb begin
      case (hostReq.addr)
         REG_ARG0: regMux = arg0_r;
         REG_ARG1: regMux = arg1_r;
         REG_STATUS: regMux = status;
         REG_RESULT: regMux = result_r;
         default: regMux = 8'h00;
      endcase
   end
   wire logic errSet = launch && (busy || !cmdOk);
   wire logic errClr = hostReq.wr && (hostReq.addr == REG_STATUS)
                       && hostReq.wdata[STAT_ERR_BIT];

   // ****************************************
   // software port
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         arg0_r <= ARG_RST;
         arg1_r <= ARG_RST;
         errFlag_r <= 1'b0;
         rdData <= 8'h00;
      end else begin
         if (hostReq.wr && (hostReq.addr == REG_ARG0)) arg0_r <= hostReq.wdata;
         if (hostReq.wr && (hostReq.addr == REG_ARG1)) arg1_r <= hostReq.wdata;
         // a new error in the clearing cycle is kept
         errFlag_r <= errSet || (errFlag_r && !errClr);
         rdData <= hostReq.rd ? regMux : 8'h00;
      end
   end

   // ****************************************
   // device data sync
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         syncA_r <= 8'h00;
         syncB_r <= 8'h00;
      end else begin
         syncA_r <= devDataIn;
         syncB_r <= syncA_r;
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   // reads hold the strobe two extra cycles so the synchroniser sees settled data
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r <= S_IDLE;
         op_r <= OP_SETMODE;
         idx_r <= 2'h0;
         cnt_r <= 4'h0;
         result_r <= 8'h00;
         sawPoll_r <= 1'b0;
         devBus_r <= '{OFF_ECR, 8'h00, 1'b0, 1'b1, 1'b1};
      end else begin
         case (state_r)
            S_IDLE: if (accept) begin
               state_r <= S_STRB;
               op_r <= newOp;
               idx_r <= startIdx;
               sawPoll_r <= 1'b0;
               cnt_r <= (first.kind == K_WR) ? STB_CYC : STB_CYC + SYNC_CYC;
               devBus_r <= '{first.addr, first.data, first.kind == K_WR,
                             first.kind == K_WR, first.kind != K_WR};
            end
            S_STRB: begin
               cnt_r <= cnt_r - 4'h1;
               if (strbEnd) begin
                  state_r <= S_RECOV;
                  cnt_r <= REC_CYC;
                  devBus_r.rdN <= 1'b1;
                  devBus_r.wrN <= 1'b1;
                  devBus_r.dataOe <= 1'b0;
                  if (isRead) result_r <= syncB_r;
                  if (isRead && !pollMiss && (cur.kind != K_RD)) sawPoll_r <= 1'b1;
                  if (!pollMiss) idx_r <= idx_r + 2'h1;
               end
            end
            S_RECOV: begin
               cnt_r <= cnt_r - 4'h1;
               if (recEnd && (cur.kind == K_END)) state_r <= S_IDLE;
               else if (recEnd) begin
                  state_r <= S_STRB;
                  cnt_r <= (cur.kind == K_WR) ? STB_CYC : STB_CYC + SYNC_CYC;
                  devBus_r <= '{cur.addr, cur.data, cur.kind == K_WR,
                                cur.kind == K_WR, cur.kind != K_WR};
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end
   assign devBus = devBus_r;

   // ****************************************
   // shadow of port mode and direction
   // ****************************************
   wire logic opDone = recEnd && (cur.kind == K_END);
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         curMode_r <= M_SPP;
         curDir_r <= 1'b0;
      end else if (opDone) begin
         if (op_r == OP_SETMODE) curMode_r <= target;
         if (op_r == OP_ECPSETUP) curMode_r <= M_ECP;
         if (op_r == OP_ECPSETUP) curDir_r <= 1'b0;
         if (op_r == OP_SETDIR) curDir_r <= arg0_r[0];
      end
   end

   // ****************************************
   // checks
   // ****************************************
   // strobe history resets inactive so no false fall follows reset
   logic wrNPrev_r;
   logic rdNPrev_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wrNPrev_r <= 1'b1;
         rdNPrev_r <= 1'b1;
      end else begin
         wrNPrev_r <= devBus_r.wrN;
         rdNPrev_r <= devBus_r.rdN;
      end
   end
   wire logic wrFall = !devBus_r.wrN && wrNPrev_r;
   wire logic rdFall = !devBus_r.rdN && rdNPrev_r;
   modeLegal_a: assert property (@(posedge clk) disable iff (sys_rst)
      (launch && !busy && (newOp == OP_SETMODE) && !modeOk) |=> errFlag_r && !busy)
      else $error("illegal mode change was started");
   dirOnlyPs2_a: assert property (@(posedge clk) disable iff (sys_rst)
      $changed(curDir_r) && ($past(op_r) == OP_SETDIR) |-> $past(curMode_r) == M_PS2)
      else $error("direction changed outside mode 001");
   drainFirst_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wrFall && (devBus_r.addr == OFF_ECR) && (op_r == OP_SETMODE) && leaveFwd)
      |-> sawPoll_r)
      else $error("left forward mode before fifo drained");
   setupOrder_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wrFall && (op_r == OP_ECPSETUP) && (devBus_r.addr == OFF_ECR))
      |-> (idx_r == 2'h1) && !devBus_r.dataOut[0])
      else $error("ecp mode set before control bits cleared");
   cmdForward_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wrFall && (devBus_r.addr == OFF_CMD_FIFO)) |-> fwdEcp && devBus_r.dataOe)
      else $error("command byte sent outside forward ecp");
   rleNonzero_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wrFall && (op_r == OP_RLE) && (idx_r == 2'h0))
      |-> !devBus_r.dataOut[CMD_MSB] && (devBus_r.dataOut[6:0] != 7'h00)
          ##[4:12] (wrFall && (devBus_r.addr == OFF_DATA_FIFO)))
      else $error("run count not followed by its data byte");
   termForward_a: assert property (@(posedge clk) disable iff (sys_rst)
      (opDone && (op_r == OP_SETMODE) && (target == M_SPP)
       && ($past(curMode_r) == M_ECP)) |-> !curDir_r)
      else $error("ecp terminated in reverse direction");
   readNotEmpty_a: assert property (@(posedge clk) disable iff (sys_rst)
      (rdFall && (op_r == OP_RDDATA) && (devBus_r.addr == OFF_DATA_FIFO)) |-> sawPoll_r
      ##1 !devBus_r.rdN [*5])
      else $error("fifo read without seeing it non-empty");

   // ****************************************
   // link timing and command checks
   // ****************************************
   wrWidth_a: assert property (@(posedge clk) disable iff (sys_rst)
      wrFall |=> !devBus_r.wrN [*3] ##1 devBus_r.wrN)
      else $error("write strobe width wrong");
   rdWidth_a: assert property (@(posedge clk) disable iff (sys_rst)
      rdFall |=> !devBus_r.rdN [*5] ##1 devBus_r.rdN)
      else $error("read strobe width wrong");
   recoverGap_a: assert property (@(posedge clk) disable iff (sys_rst)
      strbEnd |=> (devBus_r.wrN && devBus_r.rdN) ##1 (devBus_r.wrN && devBus_r.rdN))
      else $error("strobes not idle through recovery");
   oneStrobe_a: assert property (@(posedge clk) disable iff (sys_rst)
      !devBus_r.rdN |-> devBus_r.wrN)
      else $error("read and write strobes low together");
   oeWrite_a: assert property (@(posedge clk) disable iff (sys_rst)
      devBus_r.dataOe == !devBus_r.wrN)
      else $error("data driven outside a write strobe");
   strobeStable_a: assert property (@(posedge clk) disable iff (sys_rst)
      ((!devBus_r.wrN || !devBus_r.rdN) && !wrFall && !rdFall)
      |-> $stable(devBus_r.addr) && $stable(devBus_r.dataOut))
      else $error("address or data moved under a strobe");
   setupDcr_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wrFall && (op_r == OP_ECPSETUP) && (devBus_r.addr == OFF_DCR))
      |-> !devBus_r.dataOut[DCR_DIR_BIT] && (devBus_r.dataOut[1:0] == 2'h0))
      else $error("setup left direction, strobe or auto-feed set");
   dirInPs2_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wrFall && (devBus_r.addr == OFF_DCR) && (op_r == OP_SETDIR))
      |-> curMode_r == M_PS2)
      else $error("direction written outside mode 001");
   refuseErr_a: assert property (@(posedge clk) disable iff (sys_rst)
      (launch && !busy && !cmdOk) |=> errFlag_r && !busy)
      else $error("refused command started or not flagged");
   modeFollow_a: assert property (@(posedge clk) disable iff (sys_rst)
      (opDone && (op_r == OP_SETMODE)) |=> curMode_r == $past(target))
      else $error("mode shadow does not follow the mode write");
   rleData_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wrFall && (op_r == OP_RLE) && (devBus_r.addr == OFF_DATA_FIFO))
      |-> devBus_r.dataOut == arg1_r)
      else $error("run data byte differs from its argument");
   cmdPort_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wrFall && (op_r == OP_WRCMD))
      |-> (devBus_r.addr == OFF_CMD_FIFO) && (devBus_r.dataOut == arg0_r))
      else $error("command byte not sent to the command port");
   revRead_a: assert property (@(posedge clk) disable iff (sys_rst)
      (rdFall && (devBus_r.addr == OFF_DATA_FIFO) && (op_r == OP_RDDATA))
      |-> revEcp || (curMode_r == M_TEST))
      else $error("data port read outside reverse or test mode");
endmodule
`default_nettype wire

// [ecp_host_pkg.sv]
// constants and types for the host-side ecp parallel port controller
package ecp_host_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_NS = 25;
   localparam int STB_NS = 100;
   localparam int REC_NS = 50;
   localparam logic [3:0] STB_CYC = 4'((STB_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] REC_CYC = 4'((REC_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] SYNC_CYC = 4'h2;
   // ****************************************
   // device port map
   // ****************************************
   localparam logic [10:0] OFF_CMD_FIFO = 11'h000;
   localparam logic [10:0] OFF_DCR = 11'h002;
   localparam logic [10:0] OFF_DATA_FIFO = 11'h400;
   localparam logic [10:0] OFF_CFG_B = 11'h401;
   localparam logic [10:0] OFF_ECR = 11'h402;
   localparam int ECR_FULL_BIT = 1;
   localparam int ECR_EMPTY_BIT = 0;
   localparam int DCR_DIR_BIT = 5;
   localparam int CMD_MSB = 7;
   localparam logic [4:0] ECR_LOW = 5'h14;
   localparam logic [7:0] DCR_BASE = 8'h04;
   // ****************************************
   // own register map
   // ****************************************
   localparam logic [2:0] REG_ARG0 = 3'h0;
   localparam logic [2:0] REG_ARG1 = 3'h1;
   localparam logic [2:0] REG_CMD = 3'h2;
   localparam logic [2:0] REG_STATUS = 3'h3;
   localparam logic [2:0] REG_RESULT = 3'h4;
   localparam int STAT_ERR_BIT = 6;
   localparam logic [7:0] ARG_RST = 8'h00;

   typedef enum logic [2:0] {
      M_SPP = 3'h0, M_PS2 = 3'h1, M_FIFO = 3'h2, M_ECP = 3'h3,
      M_EPP = 3'h4, M_RSVD = 3'h5, M_TEST = 3'h6, M_CFG = 3'h7
   } mode_t;
   typedef enum logic [2:0] {
      OP_SETMODE = 3'h0, OP_SETDIR = 3'h1, OP_WRDATA = 3'h2, OP_WRCMD = 3'h3,
      OP_RDDATA = 3'h4, OP_ECPSETUP = 3'h5, OP_RLE = 3'h6, OP_RDCFG = 3'h7
   } op_t;
   typedef enum logic [2:0] {
      K_WR = 3'h0, K_RD = 3'h1, K_POLL_E = 3'h2, K_POLL_NE = 3'h3, K_END = 3'h4
   } kind_t;
   typedef enum logic [1:0] {
      S_IDLE = 2'h0, S_STRB = 2'h1, S_RECOV = 2'h3
   } state_t;
   typedef struct packed {
      kind_t kind;
      logic [10:0] addr;
      logic [7:0] data;
   } busop_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } host_req_t;
   typedef struct packed {
      logic [10:0] addr;
      logic [7:0] dataOut;
      logic dataOe;
      logic rdN;
      logic wrN;
   } dev_bus_t;
endpackage

// [ecp_port_model.sv]
// behavioural model of the ecp port device seen by the host controller
`timescale 1ns/1ps
`default_nettype none
module ecp_port_model #(
   parameter int DRAIN = 20,
   parameter logic [7:0] CFG_A = 8'h10,
   parameter logic [7:0] CFG_B = 8'h00
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire ecp_host_pkg::dev_bus_t devBus,
   output logic [7:0] devDataIn,
   output logic [2:0] mode_r,
   output logic [7:0] dcr_r,
   output logic [15:0] sentCnt_r,
   output logic [7:0] lastSent_r
);
   import ecp_host_pkg::*;
   logic [8:0] mem [16];
   logic [3:0] rdPtr_r, wrPtr_r;
   logic [4:0] cnt_r;
   logic [7:0] rle_r, held_r, rev_r;
   logic [5:0] tmr_r;
   logic wrPrev_r, rdPrev_r;
   // mode 010 stays forward whatever the direction bit holds
   wire logic fwd = mode_r == M_FIFO || (mode_r == M_ECP && !dcr_r[DCR_DIR_BIT]);
   wire logic rev = mode_r == M_ECP && dcr_r[DCR_DIR_BIT];
   wire logic full = cnt_r == 5'h10;
   wire logic empty = cnt_r == 5'h00;
   wire logic wrDone = !wrPrev_r && devBus.wrN;
   wire logic rdDone = !rdPrev_r && devBus.rdN;
   wire logic tick = tmr_r == 6'h00;
   // direction only moves in mode 001
   wire logic [7:0] dcrNew = {devBus.dataOut[7:6], mode_r == M_PS2 ? devBus.dataOut[5] : dcr_r[5],
      devBus.dataOut[4:0]};
   // released bus shows the inverse of the last value, so a stale sample is caught
   always_comb begin
      devDataIn = ~held_r;
      if (!devBus.rdN) begin
         case (devBus.addr)
            OFF_ECR: devDataIn = {mode_r, 3'h5, full, empty};
            OFF_DCR: devDataIn = {2'h0, dcr_r[5:0]};
            OFF_DATA_FIFO: devDataIn = mode_r == M_CFG ? CFG_A : mem[rdPtr_r][7:0];
            OFF_CFG_B: devDataIn = mode_r == M_CFG ? CFG_B : ~held_r;
            default: ;
         endcase
      end
   end
   always @(posedge clk) begin
      logic pu;
      logic po;
      logic [8:0] pv;
      pu = 1'b0;
      po = 1'b0;
      pv = {devBus.addr != OFF_CMD_FIFO, devBus.dataOut};
      wrPrev_r <= devBus.wrN | sys_rst;
      rdPrev_r <= devBus.rdN | sys_rst;
      held_r <= sys_rst ? 8'h00 : !devBus.rdN ? devDataIn : held_r;
      tmr_r <= (sys_rst || tmr_r == 6'(DRAIN - 1)) ? 6'h00 : tmr_r + 6'h01;
      if (sys_rst) begin
         mode_r <= 3'h0;
         dcr_r <= 8'h00;
         sentCnt_r <= 16'h0000;
         lastSent_r <= 8'h00;
         rle_r <= 8'h00;
         rev_r <= 8'hA0;
      end else begin
         if (wrDone && devBus.addr == OFF_ECR) mode_r <= devBus.dataOut[7:5];
         if (wrDone && devBus.addr == OFF_DCR) dcr_r <= dcrNew;
         if (wrDone && !full && (devBus.addr == OFF_DATA_FIFO ? fwd || mode_r == M_TEST
               : devBus.addr == OFF_CMD_FIFO && fwd && mode_r == M_ECP)) begin
            pu = 1'b1;
         end
         if (rev && !full && tick) begin
            pu = 1'b1;
            pv = {1'b1, rev_r};
            rev_r <= rev_r + 8'h01;
         end
         if (rdDone && devBus.addr == OFF_DATA_FIFO && !empty && (rev || mode_r == M_TEST)) begin
            po = 1'b1;
         end
         if (fwd && !empty && tick) begin
            po = 1'b1;
            if (!mem[rdPtr_r][8] && !mem[rdPtr_r][7]) begin
               rle_r <= mem[rdPtr_r][7:0];
            end else if (mem[rdPtr_r][8]) begin
               sentCnt_r <= sentCnt_r + 16'(rle_r) + 16'h0001;
               lastSent_r <= mem[rdPtr_r][7:0];
               rle_r <= 8'h00;
            end
         end
      end
      // modes 000 and 001 hold the fifo empty, so reverse leftovers go
      if (sys_rst || mode_r == M_SPP || mode_r == M_PS2) begin
         cnt_r <= 5'h00;
         rdPtr_r <= 4'h0;
         wrPtr_r <= 4'h0;
      end else begin
         if (pu) mem[wrPtr_r] <= pv;
         wrPtr_r <= wrPtr_r + 4'(pu);
         rdPtr_r <= rdPtr_r + 4'(po);
         cnt_r <= cnt_r + 5'(pu) - 5'(po);
      end
   end
endmodule
`default_nettype wire

// [ecp_parallel_port_modes_tb_top.sv]
// self-checking bench for the host-side ecp parallel port controller
`timescale 1ns/1ps
`default_nettype none
module ecp_parallel_port_modes_tb_top;
   import ecp_host_pkg::*;
   logic clk, sys_rst;
   host_req_t hostReq;
   dev_bus_t devBus;
   logic [7:0] rdData, devDataIn, dcr, lastSent, st, res, c;
   logic [2:0] mode;
   logic [15:0] sentCnt, expCnt;
   logic [31:0] seed;
   int numErrors, nChecks;
   ecp_host_ctrl dut (.clk(clk), .sys_rst(sys_rst), .hostReq(hostReq), .rdData(rdData),
      .devDataIn(devDataIn), .devBus(devBus));
   ecp_port_model dev (.clk(clk), .sys_rst(sys_rst), .devBus(devBus), .devDataIn(devDataIn),
      .mode_r(mode), .dcr_r(dcr), .sentCnt_r(sentCnt), .lastSent_r(lastSent));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic stop_test();
      if (numErrors == 0 && nChecks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      nChecks++;
      if (got !== exp) begin
         numErrors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one strobe cycle; read data lands in res
   task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d = 8'h00);
      @(posedge clk);
      hostReq <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk);
      hostReq <= '0;
      #1 res = rdData;
   endtask
   task automatic run(input op_t op, input logic [7:0] a0 = 8'h00, input logic [7:0] a1 = 8'h00);
      int n;
      bus(1, REG_ARG0, a0);
      bus(1, REG_ARG1, a1);
      bus(1, REG_CMD, {5'h00, op});
      n = 0;
      do begin
         bus(0, REG_STATUS);
         st = res;
         n++;
      end while (st[7] !== 1'b0 && n < 2000);
      if (n >= 2000) numErrors++;
   endtask
   task automatic err(input logic e);
      chk(16'(st[6]), 16'(e));
      bus(1, REG_STATUS, 8'h40);
   endtask
   task automatic result(input logic [7:0] e);
      bus(0, REG_RESULT);
      chk(16'(res), 16'(e));
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #1500000;
      numErrors++;
      stop_test();
   end
   initial begin
      sys_rst = 1'b1;
      hostReq = '0;
      seed = 32'h020C;
      numErrors = 0;
      nChecks = 0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      bus(0, REG_STATUS);
      chk(16'(res), 16'h0000);
      bus(0, 3'h5);
      chk(16'(res), 16'h0000);
      for (int m = 1; m < 8; m++) begin
         run(OP_SETMODE, 8'(m));
         chk(16'(mode), m == 5 ? 16'h0000 : 16'(m));
         err(m == 5);
         run(OP_SETMODE);
      end
      run(OP_SETMODE, 8'h07);
      run(OP_RDCFG, 8'h00);
      result(8'h10);
      run(OP_RDCFG, 8'h01);
      result(8'h00);
      run(OP_SETMODE, 8'h06);
      err(1);
      run(OP_SETMODE);
      run(OP_SETMODE, 8'h06);
      seed = lfsr(seed);
      // seventeenth byte must bounce off a full fifo
      for (int i = 0; i < 17; i++) run(OP_WRDATA, 8'(i) ^ seed[7:0]);
      for (int i = 0; i < 16; i++) begin
         run(OP_RDDATA);
         result(8'(i) ^ seed[7:0]);
      end
      chk(sentCnt, 16'h0000);
      run(OP_SETMODE);
      run(OP_ECPSETUP);
      chk({dcr, 5'h00, mode}, 16'h0403);
      expCnt = 16'h0000;
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         c = i == 0 ? 8'h00 : i == 1 ? 8'h7F : {1'b0, seed[14:8]};
         run(OP_WRCMD, 8'h80 | seed[7:0]);
         run(OP_RLE, c, seed[23:16]);
         err(c == 8'h00);
         if (c != 8'h00) expCnt += 16'(c) + 16'h0001;
         run(OP_WRDATA, seed[31:24]);
         expCnt += 16'h0001;
      end
      run(OP_SETDIR, 8'h01);
      err(1);
      run(OP_SETMODE, 8'h01);
      chk(sentCnt, expCnt);
      chk(16'(lastSent), 16'(seed[31:24]));
      run(OP_WRCMD, 8'h01);
      err(1);
      run(OP_SETDIR, 8'h01);
      run(OP_SETMODE, 8'h03);
      chk(16'(st[4:0]), 16'h0013);
      for (int i = 0; i < 3; i++) begin
         run(OP_RDDATA);
         result(8'hA0 + 8'(i));
      end
      run(OP_WRCMD, 8'h01);
      err(1);
      run(OP_SETMODE);
      err(1);
      run(OP_SETMODE, 8'h01);
      chk(16'(mode), 16'h0001);
      run(OP_SETDIR);
      run(OP_SETMODE, 8'h02);
      run(OP_WRDATA, seed[15:8]);
      run(OP_SETMODE);
      chk(sentCnt, expCnt + 16'h0001);
      chk(16'(lastSent), 16'(seed[15:8]));
      run(OP_ECPSETUP);
      run(OP_SETMODE);
      chk(16'(mode), 16'h0000);
      stop_test();
   end
endmodule
`default_nettype wire
